//--- hw/periph_irq_enable.sv
// Peripheral interrupt enable registers, network flags and request gating
//
// Functional notes
// - Without priority levels, requests pass only while the peripheral gate is set.
// - First enable bit 7 gates the parallel port interrupt.
// - First enable bit 6 gates conversion-complete interrupt.
// - First enable bits 5 and 4 gate serial receive and transmit.
// - First enable bit 3 gates sync serial, bit 2 capture unit one.
// - First enable bit 1 gates timer two period match.
// - First enable bit 0 gates timer one overflow.
// - Second enable bit 5 is absent and reads zero.
// - Comparator and enhanced capture enables exist only on large parts.
// - Mode 0: network enable bit 4 gates transmit buffer two.
// - Mode 0: network enable bit 1 gates receive buffer one.
// - Mode 0: network enable bit 0 gates receive buffer zero.
// - Network enable bit 5 gates bus error in every mode.
// - Modes 1, 2 force transmit buffer one and zero enables to zero.
// - Mode 2: network flag bit 0 sets on FIFO high watermark.
// - Flags set on their event regardless of the interrupt enables; in modes 1, 2 bits 4 and 1 set only via per-buffer enables.
// - Priority control selects two levels when 1, one level when 0.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module periph_irq_enable
	import periph_irq_pkg::*;
#(
	parameter bit LARGE_PACKAGE = 1'b1
) (
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	input  wire logic              i_ce,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_write,
	input  wire logic              i_read,
	output logic      [DATA_W-1:0] o_rdata,
	input  wire logic [7:0]        i_first_flags,
	input  wire logic [7:0]        i_second_flags,
	input  wire logic [7:0]        i_net_event,
	input  wire logic [7:0]        i_tx_buffer_event,
	input  wire logic [7:0]        i_rx_buffer_event,
	input  wire logic              i_fifo_high_mark,
	output logic                   o_periph_pending,
	output logic                   o_irq_single,
	output logic                   o_irq_prioritised
);
	logic [7:0] peripheral_enable_first;
	logic [7:0] peripheral_enable_second;
	logic [7:0] network_interrupt_enable;
	logic [7:0] network_interrupt_flags;
	logic [7:0] per_tx_buffer_enables;
	logic [7:0] per_buffer_enables;
	logic       priority_levels_on;
	logic       global_peripheral_gate;
	logic [1:0] net_mode;
	logic [7:0] second_mask;
	logic [7:0] net_en_mask;
	logic [7:0] net_flag_mask;
	logic [7:0] second_eff;
	logic [7:0] net_en_eff;
	logic [7:0] net_flags_view;
	logic [7:0] net_set;
	logic       legacy;
	logic       wr_flags;
	logic [7:0] next_rdata;

	assign legacy      = (net_mode == MODE_LEGACY);
	assign second_mask = LARGE_PACKAGE ? SECOND_MASK_LARGE : SECOND_MASK_SMALL;

	// Per-mode view of the network enables and flags
	always_comb begin
		net_en_mask   = NET_EN_MASK_LEGACY;
		net_flag_mask = NET_EN_MASK_LEGACY;
		case (net_mode)
			MODE_ENHANCED: begin
				net_en_mask   = NET_EN_MASK_ENHANCED;
				net_flag_mask = NET_FLAG_MASK_ENHANCED;
			end
			MODE_FIFO: begin
				net_en_mask   = NET_EN_MASK_FIFO;
			end
			default: begin
				net_en_mask   = NET_EN_MASK_LEGACY;
			end
		endcase
	end

	assign second_eff     = peripheral_enable_second & second_mask;
	assign net_en_eff     = network_interrupt_enable & net_en_mask;
	assign net_flags_view = network_interrupt_flags & net_flag_mask;

	// Flag set terms
	always_comb begin
		net_set                = i_net_event;
		net_set[NET_TX_TWO]    = legacy ? i_net_event[NET_TX_TWO]
			: |(i_tx_buffer_event & per_tx_buffer_enables);
		net_set[NET_RX_ONE]    = legacy ? i_net_event[NET_RX_ONE]
			: |(i_rx_buffer_event & per_buffer_enables);
		net_set[NET_RX_ZERO]   = 1'b0;
		if (legacy) begin
			net_set[NET_RX_ZERO] = i_net_event[NET_RX_ZERO];
		end else if (net_mode == MODE_FIFO) begin
			net_set[NET_RX_ZERO] = i_fifo_high_mark;
		end
	end

	assign wr_flags = i_write && (i_addr == OFF_NET_FLAGS);

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_flag
			sticky_flag u_flag (
				.i_clock       (i_clock),
				.i_rst         (i_rst),
				.i_ce          (i_ce),
				.i_set         (net_set[g]),
				.i_write       (wr_flags),
				.i_write_value (i_wdata[g]),
				.o_flag        (network_interrupt_flags[g])
			);
		end
	endgenerate

	// Enable registers
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			peripheral_enable_first  <= RST_ENABLE;
			peripheral_enable_second <= RST_ENABLE;
			network_interrupt_enable <= RST_ENABLE;
		end else if (i_ce && i_write) begin
			if (i_addr == OFF_ENABLE_FIRST) begin
				peripheral_enable_first <= i_wdata;
			end else if (i_addr == OFF_ENABLE_SECOND) begin
				peripheral_enable_second <= i_wdata & second_mask;
			end else if (i_addr == OFF_NET_ENABLE) begin
				network_interrupt_enable <= i_wdata;
			end
		end
	end

	// Control and per-buffer enables
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			priority_levels_on     <= 1'b0;
			global_peripheral_gate <= 1'b0;
			net_mode               <= RST_MODE;
			per_tx_buffer_enables  <= RST_BUF_EN;
			per_buffer_enables     <= RST_BUF_EN;
		end else if (i_ce && i_write) begin
			if (i_addr == OFF_CONTROL) begin
				priority_levels_on     <= i_wdata[CTL_PRIORITY_BIT];
				global_peripheral_gate <= i_wdata[CTL_GATE_BIT];
				// Mode code 3 is undefined and leaves the mode unchanged
				if (i_wdata[CTL_MODE_LSB+1:CTL_MODE_LSB] != 2'h3) begin
					net_mode <= i_wdata[CTL_MODE_LSB+1:CTL_MODE_LSB];
				end
			end else if (i_addr == OFF_TX_BUF_EN) begin
				per_tx_buffer_enables <= i_wdata;
			end else if (i_addr == OFF_BUF_EN) begin
				per_buffer_enables <= i_wdata;
			end
		end
	end

	// Request combining
	assign o_periph_pending = |(i_first_flags & peripheral_enable_first)
		| |(i_second_flags & second_eff)
		| |(net_flags_view & net_en_eff);
	assign o_irq_single      = !priority_levels_on && global_peripheral_gate
		&& o_periph_pending;
	assign o_irq_prioritised = priority_levels_on && o_periph_pending;

	// Read mux
	always_comb begin
		next_rdata = 8'h00;
		if (i_addr == OFF_NET_FLAGS) begin
			next_rdata = net_flags_view;
		end else if (i_addr == OFF_ENABLE_FIRST) begin
			next_rdata = peripheral_enable_first;
		end else if (i_addr == OFF_ENABLE_SECOND) begin
			next_rdata = second_eff;
		end else if (i_addr == OFF_NET_ENABLE) begin
			next_rdata = net_en_eff;
		end else if (i_addr == OFF_CONTROL) begin
			next_rdata[CTL_PRIORITY_BIT]               = priority_levels_on;
			next_rdata[CTL_GATE_BIT]                   = global_peripheral_gate;
			next_rdata[CTL_MODE_LSB+1:CTL_MODE_LSB]    = net_mode;
		end else if (i_addr == OFF_TX_BUF_EN) begin
			next_rdata = per_tx_buffer_enables;
		end else if (i_addr == OFF_BUF_EN) begin
			next_rdata = per_buffer_enables;
		end else if (i_addr == OFF_STATUS) begin
			next_rdata[STAT_PENDING_BIT] = o_periph_pending;
			next_rdata[STAT_SINGLE_BIT]  = o_irq_single;
			next_rdata[STAT_PRIO_BIT]    = o_irq_prioritised;
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (i_ce) begin
			o_rdata <= i_read ? next_rdata : 8'h00;
		end
	end

	sequence s_read_second;
		i_ce && i_read && (i_addr == OFF_ENABLE_SECOND);
	endsequence

	sequence s_fifo_mark;
		i_ce && (net_mode == MODE_FIFO) && i_fifo_high_mark;
	endsequence

	a_gate_blocks_single: assert property (@(posedge i_clock) disable iff (i_rst)
		(!global_peripheral_gate || priority_levels_on) |-> !o_irq_single)
		else $error("Single-level request without peripheral gate");

	a_parallel_port_gate: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_first_flags[7] && peripheral_enable_first[7] && global_peripheral_gate
		&& !priority_levels_on) |-> o_irq_single)
		else $error("Parallel port request not forwarded");

	a_second_bit5_zero: assert property (@(posedge i_clock) disable iff (i_rst)
		s_read_second |=> (o_rdata[5] == 1'b0))
		else $error("Second enable bit 5 read as one");

	a_fifo_sets_flag: assert property (@(posedge i_clock) disable iff (i_rst)
		s_fifo_mark |=> network_interrupt_flags[NET_RX_ZERO])
		else $error("Watermark did not set flag");

	a_tx_low_forced: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_ce && i_read && (i_addr == OFF_NET_ENABLE) && !legacy)
		|=> (o_rdata[NET_TX_ONE:NET_TX_ZERO] == 2'h0))
		else $error("Transmit one/zero enables not forced in modes 1, 2");

	a_bus_error_gate: assert property (@(posedge i_clock) disable iff (i_rst)
		(network_interrupt_flags[NET_BUS_ERROR] && network_interrupt_enable[NET_BUS_ERROR])
		|-> o_periph_pending)
		else $error("Bus error request missing");

	a_no_pending_idle: assert property (@(posedge i_clock) disable iff (i_rst)
		((i_first_flags & peripheral_enable_first) == 8'h00
		&& (i_second_flags & second_eff) == 8'h00
		&& (net_flags_view & net_en_eff) == 8'h00) |-> !o_periph_pending)
		else $error("Request without flag and enable");

	a_flag_without_enable: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_ce && legacy && i_net_event[NET_TX_TWO] && !network_interrupt_enable[NET_TX_TWO])
		|=> network_interrupt_flags[NET_TX_TWO])
		else $error("Flag not set while disabled");

	a_mode1_bit0_zero: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_ce && i_read && (i_addr == OFF_NET_ENABLE) && (net_mode == MODE_ENHANCED))
		|=> (o_rdata[NET_RX_ZERO] == 1'b0))
		else $error("Mode 1 enable bit 0 not zero");

	a_read_one_cycle: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_ce && !i_read) |=> (o_rdata == 8'h00))
		else $error("Read data outside read slot");
endmodule // periph_irq_enable

//--- hw/sticky_flag.sv
// One interrupt flag bit: hardware set beats software write
`timescale 1ns/1ps
module sticky_flag
	import periph_irq_pkg::*;
(
	input  wire logic i_clock,
	input  wire logic i_rst,
	input  wire logic i_ce,
	input  wire logic i_set,
	input  wire logic i_write,
	input  wire logic i_write_value,
	output logic      o_flag
);
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_flag <= 1'b0;
		end else if (i_ce) begin
			if (i_set) begin
				o_flag <= 1'b1;
			end else if (i_write) begin
				o_flag <= i_write_value;
			end
		end
	end

	a_set_wins_clear: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_ce && i_set) |=> o_flag)
		else $error("Flag lost a set event");
endmodule // sticky_flag

//--- shared/periph_irq_pkg.sv
// Register map, field positions and reset values of the peripheral interrupt enable block
package periph_irq_pkg;
	localparam int  DATA_W = 8;
	localparam int  ADDR_W = 4;

	// Register offsets
	localparam logic [3:0] OFF_NET_FLAGS     = 4'h0;
	localparam logic [3:0] OFF_ENABLE_FIRST  = 4'h1;
	localparam logic [3:0] OFF_ENABLE_SECOND = 4'h2;
	localparam logic [3:0] OFF_NET_ENABLE    = 4'h3;
	localparam logic [3:0] OFF_CONTROL       = 4'h4;
	localparam logic [3:0] OFF_TX_BUF_EN     = 4'h5;
	localparam logic [3:0] OFF_BUF_EN        = 4'h6;
	localparam logic [3:0] OFF_STATUS        = 4'h7;

	// Reset values
	localparam logic [7:0] RST_ENABLE   = 8'h00;
	localparam logic [7:0] RST_FLAGS    = 8'h00;
	localparam logic [7:0] RST_BUF_EN   = 8'h00;
	localparam logic [1:0] RST_MODE     = 2'h0;

	// Control register fields
	localparam int  CTL_PRIORITY_BIT = 0;
	localparam int  CTL_GATE_BIT     = 1;
	localparam int  CTL_MODE_LSB     = 2;

	// Network mode encodings
	localparam logic [1:0] MODE_LEGACY   = 2'h0;
	localparam logic [1:0] MODE_ENHANCED = 2'h1;
	localparam logic [1:0] MODE_FIFO     = 2'h2;

	// Bit positions of the network flag and enable registers
	localparam int  NET_BUS_ERROR = 5;
	localparam int  NET_TX_TWO    = 4;
	localparam int  NET_TX_ONE    = 3;
	localparam int  NET_TX_ZERO   = 2;
	localparam int  NET_RX_ONE    = 1;
	localparam int  NET_RX_ZERO   = 0;

	// Second enable register: bit 5 absent, bits 6 and 0 only on large parts
	localparam logic [7:0] SECOND_MASK_LARGE = 8'hdf;
	localparam logic [7:0] SECOND_MASK_SMALL = 8'h9e;

	// Network enable masks per mode
	localparam logic [7:0] NET_EN_MASK_LEGACY   = 8'hff;
	localparam logic [7:0] NET_EN_MASK_ENHANCED = 8'hf2;
	localparam logic [7:0] NET_EN_MASK_FIFO     = 8'hf3;
	localparam logic [7:0] NET_FLAG_MASK_ENHANCED = 8'hfe;

	// Status register fields
	localparam int  STAT_PENDING_BIT = 0;
	localparam int  STAT_SINGLE_BIT  = 1;
	localparam int  STAT_PRIO_BIT    = 2;
endpackage

//--- testbench/event_source.sv
// Behavioural peripheral event sources feeding the interrupt block
`timescale 1ns/1ps
module event_source #(
	parameter bit LARGE = 1'b1
) (
	input  wire logic       i_clock,
	input  wire logic       i_go,
	input  wire logic [7:0] i_first,
	input  wire logic [7:0] i_net,
	input  wire logic [7:0] i_tx,
	input  wire logic [7:0] i_rx,
	input  wire logic       i_fifo,
	output logic      [7:0] o_first,
	output logic      [7:0] o_net,
	output logic      [7:0] o_tx,
	output logic      [7:0] o_rx,
	output logic            o_fifo
);
	// Parallel port flag held clear on small parts
	assign o_first = LARGE ? i_first : (i_first & 8'h7f);
	// Events last one cycle, then drop
	always_ff @(posedge i_clock) begin
		o_net  <= i_go ? i_net : 8'h00;
		o_tx   <= i_go ? i_tx : 8'h00;
		o_rx   <= i_go ? i_rx : 8'h00;
		o_fifo <= i_go & i_fifo;
	end
endmodule // event_source

//--- testbench/tb_top.sv
// Self-checking bench for the peripheral interrupt enable block
`timescale 1ns/1ps
module tb_top
	import periph_irq_pkg::*;
;
	logic       i_clock = 1'b0;
	logic       i_rst   = 1'b1;
	logic       i_write = 1'b0;
	logic       i_read  = 1'b0;
	logic       go      = 1'b0;
	logic       fifo    = 1'b0;
	logic       ce      = 1'b1;
	logic [3:0] i_addr  = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic [7:0] first   = 8'h00;
	logic [7:0] second  = 8'h00;
	logic [7:0] net     = 8'h00;
	logic [7:0] tx      = 8'h00;
	logic [7:0] rx      = 8'h00;
	logic [7:0] o_rdata, o_rdata_small, f_first, f_net, f_tx, f_rx;
	logic       o_periph_pending, o_irq_single, o_irq_prioritised, f_fifo;
	logic [7:0] mask [3] = '{8'hff, 8'hf2, 8'hf3};
	int         n_mismatch  = 0;
	int         checks_done = 0;
	int         k;

	always #5 i_clock = ~i_clock;

	event_source src (.i_clock(i_clock), .i_go(go), .i_first(first), .i_net(net),
		.i_tx(tx), .i_rx(rx), .i_fifo(fifo), .o_first(f_first), .o_net(f_net),
		.o_tx(f_tx), .o_rx(f_rx), .o_fifo(f_fifo));
	periph_irq_enable #(.LARGE_PACKAGE(1'b1)) dut (.i_clock(i_clock), .i_rst(i_rst),
		.i_ce(ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
		.i_read(i_read), .o_rdata(o_rdata), .i_first_flags(f_first),
		.i_second_flags(second), .i_net_event(f_net), .i_tx_buffer_event(f_tx),
		.i_rx_buffer_event(f_rx), .i_fifo_high_mark(f_fifo),
		.o_periph_pending(o_periph_pending), .o_irq_single(o_irq_single),
		.o_irq_prioritised(o_irq_prioritised));
	// Small-package variant on the same bus, only its register view is checked
	periph_irq_enable #(.LARGE_PACKAGE(1'b0)) dut_small (.i_clock(i_clock), .i_rst(i_rst),
		.i_ce(ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
		.i_read(i_read), .o_rdata(o_rdata_small), .i_first_flags(f_first),
		.i_second_flags(second), .i_net_event(f_net), .i_tx_buffer_event(f_tx),
		.i_rx_buffer_event(f_rx), .i_fifo_high_mark(f_fifo),
		.o_periph_pending(), .o_irq_single(),
		.o_irq_prioritised());

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_write <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_write <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge i_clock);
		i_read <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_read <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask

	// Outputs packed as prioritised, single, pending
	task automatic cko(input logic [2:0] exp);
		#1 chk({5'h00, o_irq_prioritised, o_irq_single, o_periph_pending}, {5'h00, exp});
	endtask

	task automatic fire(input logic [7:0] n, input logic [7:0] t, input logic [7:0] r,
		input logic f);
		@(posedge i_clock);
		go   <= 1'b1;
		net  <= n;
		tx   <= t;
		rx   <= r;
		fifo <= f;
		@(posedge i_clock);
		go <= 1'b0;
		@(posedge i_clock);
	endtask

	// Level flags of the first and second groups, changed at a rising edge
	task automatic set_flags(input logic [7:0] f, input logic [7:0] s);
		@(posedge i_clock);
		first  <= f;
		second <= s;
	endtask

	initial begin
		repeat (20) @(posedge i_clock);
		i_rst <= 1'b0;
		for (k = 0; k < 9; k++)
			rd(k[3:0], 8'h00);
		// A write with the clock enable low is ignored
		ce <= 1'b0;
		wr(OFF_ENABLE_FIRST, 8'hff);
		ce <= 1'b1;
		rd(OFF_ENABLE_FIRST, 8'h00);
		wr(OFF_CONTROL, 8'h02);
		for (k = 0; k < 8; k++) begin
			set_flags(8'h01 << k, 8'h00);
			wr(OFF_ENABLE_FIRST, ~(8'h01 << k));
			cko(3'b000);
			wr(OFF_ENABLE_FIRST, 8'h01 << k);
			cko(3'b011);
		end
		wr(OFF_CONTROL, 8'h00);
		cko(3'b001);
		rd(OFF_STATUS, 8'h01);
		wr(OFF_CONTROL, 8'h01);
		cko(3'b101);
		wr(OFF_CONTROL, 8'h03);
		rd(OFF_STATUS, 8'h05);
		set_flags(8'h00, 8'h00);
		wr(OFF_CONTROL, 8'h02);
		cko(3'b000);
		wr(OFF_ENABLE_SECOND, 8'hff);
		rd(OFF_ENABLE_SECOND, 8'hdf);
		chk(o_rdata_small, 8'h9e);
		set_flags(8'h00, 8'h20);
		cko(3'b000);
		set_flags(8'h00, 8'h41);
		cko(3'b011);
		set_flags(8'h00, 8'h00);
		wr(OFF_NET_ENABLE, 8'hff);
		for (k = 0; k < 3; k++) begin
			wr(OFF_CONTROL, {4'h0, k[1:0], 2'b10});
			rd(OFF_NET_ENABLE, mask[k]);
		end
		wr(OFF_NET_ENABLE, 8'h00);
		wr(OFF_CONTROL, 8'h02);
		fire(8'h3f, 8'h00, 8'h00, 1'b0);
		rd(OFF_NET_FLAGS, 8'h3f);
		cko(3'b000);
		for (k = 0; k < 6; k++) begin
			wr(OFF_NET_ENABLE, 8'h01 << k);
			cko(3'b011);
		end
		wr(OFF_CONTROL, 8'h06);
		wr(OFF_NET_ENABLE, 8'h0d);
		cko(3'b000);
		wr(OFF_NET_ENABLE, 8'h20);
		cko(3'b011);
		wr(OFF_NET_FLAGS, 8'h00);
		wr(OFF_NET_ENABLE, 8'h00);
		wr(OFF_TX_BUF_EN, 8'h01);
		wr(OFF_BUF_EN, 8'h02);
		fire(8'h00, 8'h02, 8'h01, 1'b1);
		rd(OFF_NET_FLAGS, 8'h00);
		fire(8'h00, 8'h01, 8'h02, 1'b0);
		rd(OFF_NET_FLAGS, 8'h12);
		wr(OFF_NET_ENABLE, 8'h10);
		cko(3'b011);
		wr(OFF_NET_ENABLE, 8'h02);
		cko(3'b011);
		wr(OFF_CONTROL, 8'h0a);
		wr(OFF_NET_FLAGS, 8'h00);
		rd(OFF_NET_FLAGS, 8'h00);
		fire(8'h00, 8'h00, 8'h00, 1'b1);
		rd(OFF_NET_FLAGS, 8'h01);
		wr(OFF_NET_ENABLE, 8'h01);
		cko(3'b011);
		// Undefined mode code keeps the current mode
		wr(OFF_CONTROL, 8'h0e);
		rd(OFF_CONTROL, 8'h0a);
		report_and_stop();
	end
endmodule // tb_top
